// ---- logic/rx_cfg_params.svh ----
// Register offsets, field positions and reset values of the receive config
`ifndef RX_CFG_PARAMS_SVH
`define RX_CFG_PARAMS_SVH

// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define INT_STS_OFS      8'h58
`define INT_EN_OFS       8'h5C
`define RX_CFG_OFS       8'h6C

// ***********************************************************************
// Receive configuration and interrupt fields
// ***********************************************************************
`define ALIGN_HI         31
`define ALIGN_LO         30
`define CNT_HI           27
`define CNT_LO           16
`define DISCARD_BIT      15
`define OFS_HI           12
`define OFS_LO           8
`define OFS_DW_LO        10
`define RXD_INT_BIT      20

// ***********************************************************************
// Reset values and encodings
// ***********************************************************************
`define ALIGN_RST        2'h0
`define CNT_RST          12'h000
`define OFS_RST          5'h00
`define ALIGN_4          2'h0
`define ALIGN_16         2'h1
`define ALIGN_32         2'h2
`define BYTES_4          6'h04
`define BYTES_16         6'h10
`define BYTES_32         6'h20
`define ZERO_WORD        32'h0000_0000

`endif

// ---- logic/rx_cfg_pkg.sv ----
// Types shared by the receive configuration block
package rx_cfg_pkg;

   // Host bus request, one cycle per access
   typedef struct packed
   {
      logic        sel;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } bus_req_t;

   // Settings handed to the receive data read path
   typedef struct packed
   {
      logic [5:0] end_align_bytes;
      logic [4:0] lead_offset;
   } read_cfg_t;

endpackage

// ---- logic/rx_dword_countdown.sv ----
// DWORD countdown that flags the last read of a programmed amount
`timescale 1ns/1ps
module rx_dword_countdown
   import rx_cfg_pkg::*;
#(
   parameter int CW = 12
)
(
   // Clock and reset
   input  wire logic          clock_i,
   input  wire logic          rstn_i,
   // Control
   input  wire logic          load_i,
   input  wire logic [CW-1:0] load_val_i,
   input  wire logic          dec_i,
   // Status
   output logic [CW-1:0]      count_o,
   output logic               done_o
);

   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic          done_r;
   logic          done_nxt;
   logic          live_dec;

   // A stopped count of zero never wraps or fires again
   assign live_dec  = dec_i && (count_r != '0);
   // A fresh load replaces a running count
   assign count_nxt = load_i   ? load_val_i :
                      live_dec ? count_r - 1'b1 : count_r;
   assign done_nxt  = !load_i && live_dec && (count_r == CW'(1));

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         count_r <= '0;
         done_r  <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         done_r  <= done_nxt;
      end
   end

   assign count_o = count_r;
   assign done_o  = done_r;

endmodule

// ---- logic/host_rx_fifo_read_config.sv ----
// Receive configuration register and its effect on receive FIFO reads
`timescale 1ns/1ps
`include "rx_cfg_params.svh"
module host_rx_fifo_read_config
   import rx_cfg_pkg::*;
#(
   parameter int CW = 12
)
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   // Host register bus
   input  wire bus_req_t    bus_req_i,
   output logic [31:0]      bus_rdata_o,
   output logic             bus_ack_o,
   // Receive data FIFO read path
   input  wire logic        rx_dword_rd_i,
   output read_cfg_t        read_cfg_o,
   output logic             rx_flush_o,
   // Interrupt
   output logic             irq_o
);

   // ***********************************************************************
   // Address decode
   // ***********************************************************************
   function automatic logic hit(input bus_req_t r, input logic [7:0] ofs);
      hit = r.sel && (r.addr == ofs);
   endfunction

   function automatic logic [5:0] align_bytes(input logic [1:0] code);
      // Reserved code falls back to plain DWORD padding
      unique case (code)
         `ALIGN_16: align_bytes = `BYTES_16;
         `ALIGN_32: align_bytes = `BYTES_32;
         default:   align_bytes = `BYTES_4;
      endcase
   endfunction

   logic          wr_cfg;
   logic          wr_en;
   logic          wr_sts;
   logic          rd_any;
   logic [1:0]    align_r;
   logic [4:0]    ofs_r;
   logic [2:0]    ofs_dw_live_r;
   logic          rxd_en_r;
   logic          rxd_sts_r;
   logic          rxd_sts_nxt;
   logic          flush_r;
   logic          ack_r;
   logic [31:0]   rdata_r;
   logic [31:0]   rdata_nxt;
   logic [31:0]   cfg_view;
   read_cfg_t     cfg_out_r;
   read_cfg_t     cfg_out_nxt;
   logic          irq_r;
   logic [CW-1:0] count;
   logic          count_done;

   assign wr_cfg = hit(bus_req_i, `RX_CFG_OFS) && bus_req_i.wr;
   assign wr_en  = hit(bus_req_i, `INT_EN_OFS) && bus_req_i.wr;
   assign wr_sts = hit(bus_req_i, `INT_STS_OFS) && bus_req_i.wr;
   assign rd_any = bus_req_i.sel && !bus_req_i.wr;

   // ***********************************************************************
   // DWORD countdown
   // ***********************************************************************
   rx_dword_countdown #(
      .CW         (CW)
   ) u_countdown (
      .clock_i    (clock_i),
      .rstn_i     (rstn_i),
      .load_i     (wr_cfg),
      .load_val_i (bus_req_i.wdata[`CNT_HI:`CNT_LO]),
      .dec_i      (rx_dword_rd_i),
      .count_o    (count),
      .done_o     (count_done)
   );

   // ***********************************************************************
   // Configuration fields
   // ***********************************************************************
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         align_r <= `ALIGN_RST;
         ofs_r   <= `OFS_RST;
         flush_r <= 1'b0;
      end
      else
      begin
         if (wr_cfg)
         begin
            align_r <= bus_req_i.wdata[`ALIGN_HI:`ALIGN_LO];
            ofs_r   <= bus_req_i.wdata[`OFS_HI:`OFS_LO];
         end
         // Self-clearing: a one-cycle pulse, never stored
         flush_r <= wr_cfg && bus_req_i.wdata[`DISCARD_BIT];
      end
   end

   // Upper offset bits follow the field only on a DWORD read or a flush, so a
   // live change never splits a word already being read
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ofs_dw_live_r <= 3'h0;
      else if (rx_dword_rd_i || flush_r)
         ofs_dw_live_r <= ofs_r[4:2];
   end

   // Low offset bits are used directly; host keeps them still
   assign cfg_out_nxt.end_align_bytes = align_bytes(align_r);
   assign cfg_out_nxt.lead_offset     = {ofs_dw_live_r, ofs_r[1:0]};

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cfg_out_r <= '{end_align_bytes: `BYTES_4, lead_offset: `OFS_RST};
      else
         cfg_out_r <= cfg_out_nxt;
   end

   // ***********************************************************************
   // Receive DMA interrupt
   // ***********************************************************************
   // Set wins over a same-cycle write-one-to-clear
   assign rxd_sts_nxt = count_done ? 1'b1 :
                        (wr_sts && bus_req_i.wdata[`RXD_INT_BIT]) ? 1'b0 :
                        rxd_sts_r;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rxd_en_r  <= 1'b0;
         rxd_sts_r <= 1'b0;
         irq_r     <= 1'b0;
      end
      else
      begin
         if (wr_en)
            rxd_en_r <= bus_req_i.wdata[`RXD_INT_BIT];
         rxd_sts_r <= rxd_sts_nxt;
         irq_r     <= rxd_sts_r && rxd_en_r;
      end
   end

   // ***********************************************************************
   // Register read-back
   // ***********************************************************************
   // Discard bit and reserved ranges read zero
   assign cfg_view = {align_r, 2'h0, count, 1'b0, 2'h0, ofs_r, 8'h00};

   assign rdata_nxt =
      !rd_any                      ? `ZERO_WORD :
      hit(bus_req_i, `RX_CFG_OFS)  ? cfg_view :
      hit(bus_req_i, `INT_EN_OFS)  ? (32'(rxd_en_r)  << `RXD_INT_BIT) :
      hit(bus_req_i, `INT_STS_OFS) ? (32'(rxd_sts_r) << `RXD_INT_BIT) :
                                     `ZERO_WORD;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ack_r   <= 1'b0;
         rdata_r <= `ZERO_WORD;
      end
      else
      begin
         ack_r   <= bus_req_i.sel;
         rdata_r <= rdata_nxt;
      end
   end

   assign bus_rdata_o = rdata_r;
   assign bus_ack_o   = ack_r;
   assign read_cfg_o  = cfg_out_r;
   assign rx_flush_o  = flush_r;
   assign irq_o       = irq_r;

   // ***********************************************************************
   // Assertions
   // ***********************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence s_discard_write;
      wr_cfg && bus_req_i.wdata[`DISCARD_BIT];
   endsequence

   sequence s_one_pulse;
      rx_flush_o ##1 !rx_flush_o;
   endsequence

   align_pad_out_a: assert property (
      wr_cfg |-> ##2 read_cfg_o.end_align_bytes ==
         align_bytes($past(bus_req_i.wdata[`ALIGN_HI:`ALIGN_LO], 2)))
      else $error("end alignment bytes do not follow written code");

   dma_irq_set_a: assert property (
      (rx_dword_rd_i && !wr_cfg && count == CW'(1)) |-> ##2 rxd_sts_r)
      else $error("status not set after final counted DWORD");

   count_dec_a: assert property (
      (rx_dword_rd_i && !wr_cfg && count != '0) |=>
         count == $past(count) - CW'(1))
      else $error("countdown did not step on DWORD read");

   count_reload_a: assert property (
      wr_cfg |=> count == $past(bus_req_i.wdata[`CNT_HI:`CNT_LO]))
      else $error("written count did not replace running count");

   discard_pulse_a: assert property (
      (s_discard_write ##1 !wr_cfg) |-> s_one_pulse)
      else $error("discard did not give a single flush pulse");

   offset_store_a: assert property (
      wr_cfg |=> ofs_r == $past(bus_req_i.wdata[`OFS_HI:`OFS_LO]))
      else $error("lead offset field not stored");

   upper_hold_a: assert property (
      (!rx_dword_rd_i && !flush_r) |=> $stable(ofs_dw_live_r))
      else $error("upper offset changed between DWORD reads");

   irq_gate_a: assert property (
      irq_o == ($past(rxd_sts_r) && $past(rxd_en_r)))
      else $error("interrupt output not gated by enable");

   reserved_zero_a: assert property (
      (rd_any && hit(bus_req_i, `RX_CFG_OFS)) |=>
         (bus_rdata_o[29:28] == 2'h0) && (bus_rdata_o[15:13] == 3'h0) &&
         (bus_rdata_o[7:0] == 8'h00))
      else $error("reserved config bits read non-zero");

endmodule

// ---- test/host_cpu_model.sv ----
// Host CPU model issuing register accesses and receive data reads
`timescale 1ns/1ps
module host_cpu_model
   import rx_cfg_pkg::*;
(
   // Clock
   input  wire logic        clock_i,
   // Host register bus
   output bus_req_t         bus_req_o,
   input  wire logic [31:0] bus_rdata_i,
   input  wire logic        bus_ack_i,
   // Receive data FIFO reads
   output logic             dword_rd_o
);
   initial
   begin
      bus_req_o  = '0;
      dword_rd_o = 1'b0;
   end

   // ***************************************************
   // Bus access, held over exactly one rising edge
   // ***************************************************
   task automatic access(input logic wr, input logic [7:0] addr,
                         input logic [31:0] wdata,
                         output logic [31:0] rdata, output logic ack);
   begin
      @(negedge clock_i);
      bus_req_o = '{sel: 1'b1, wr: wr, addr: addr, wdata: wdata};
      @(negedge clock_i);
      rdata = bus_rdata_i;
      ack = bus_ack_i;
      // Released lines show no stale value
      bus_req_o = '{sel: 1'b0, wr: ~wr, addr: ~addr, wdata: ~wdata};
   end
   endtask

   // One DWORD pulled; caller keeps align and low offset steady
   task automatic dword_read();
   begin
      @(negedge clock_i);
      dword_rd_o = 1'b1;
      @(negedge clock_i);
      dword_rd_o = 1'b0;
   end
   endtask
endmodule

// ---- test/host_rx_fifo_read_config_tb_top.sv ----
// Testbench for the receive configuration block
`timescale 1ns/1ps
`include "rx_cfg_params.svh"
module host_rx_fifo_read_config_tb_top
   import rx_cfg_pkg::*;
;
   logic        clock_i = 1'b0;
   logic        rstn_i = 1'b0;
   bus_req_t    bus_req;
   logic [31:0] bus_rdata;
   logic        bus_ack;
   logic        dword_rd;
   read_cfg_t   read_cfg;
   logic        rx_flush;
   logic        irq;
   int          fails = 0;
   int          n_checks = 0;
   logic [5:0]  pad_tbl [4] = '{6'h04, 6'h10, 6'h20, 6'h04};

   always #2.5 clock_i = ~clock_i;

   host_cpu_model host (.clock_i(clock_i), .bus_req_o(bus_req),
      .bus_rdata_i(bus_rdata), .bus_ack_i(bus_ack),
      .dword_rd_o(dword_rd));

   host_rx_fifo_read_config dut (.clock_i(clock_i), .rstn_i(rstn_i),
      .bus_req_i(bus_req), .bus_rdata_o(bus_rdata), .bus_ack_o(bus_ack),
      .rx_dword_rd_i(dword_rd), .read_cfg_o(read_cfg),
      .rx_flush_o(rx_flush), .irq_o(irq));

   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        k;
   begin
      host.access(1'b1, a, d, r, k);
      check({31'h0, k}, 32'h1);
      check(32'(rx_flush), 32'(a == `RX_CFG_OFS && d[15]));
   end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic        k;
   begin
      host.access(1'b0, a, 32'h0000_0000, r, k);
      check({31'h0, k}, 32'h1);
      check(r, e);
   end
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset();
   begin
      rd(`RX_CFG_OFS, 32'h0000_0000);
      check(32'(read_cfg.end_align_bytes), 32'h0000_0004);
      check(32'(read_cfg.lead_offset), 32'h0000_0000);
   end
   endtask

   task automatic t_align();
   begin
      for (int i = 0; i < 4; i++)
      begin
         wr(`RX_CFG_OFS, {i[1:0], 30'h0});
         @(negedge clock_i);
         check(32'(read_cfg.end_align_bytes), 32'(pad_tbl[i]));
         rd(`RX_CFG_OFS, {i[1:0], 30'h0});
      end
   end
   endtask

   task automatic t_reserved();
   begin
      wr(`RX_CFG_OFS, 32'hFFFF_FFFF);
      @(negedge clock_i);
      check(32'(rx_flush), 32'h0000_0000);
      rd(`RX_CFG_OFS, 32'hCFFF_1F00);
      wr(`RX_CFG_OFS, 32'h0000_0000);
      wr(8'h60, 32'hFFFF_FFFF);
      rd(8'h60, 32'h0000_0000);
   end
   endtask

   task automatic t_count();
   begin
      wr(`INT_EN_OFS, 32'h0010_0000);
      rd(`INT_EN_OFS, 32'h0010_0000);
      wr(`RX_CFG_OFS, 32'h0003_0000);
      host.dword_read();
      host.dword_read();
      rd(`RX_CFG_OFS, 32'h0001_0000);
      wr(`RX_CFG_OFS, 32'h0002_0000);
      rd(`RX_CFG_OFS, 32'h0002_0000);
      host.dword_read();
      repeat (3) @(negedge clock_i);
      check(32'(irq), 32'h0000_0000);
      host.dword_read();
      repeat (3) @(negedge clock_i);
      check(32'(irq), 32'h0000_0001);
      rd(`INT_STS_OFS, 32'h0010_0000);
      wr(`INT_STS_OFS, 32'h0010_0000);
      repeat (2) @(negedge clock_i);
      check(32'(irq), 32'h0000_0000);
      wr(`INT_EN_OFS, 32'h0000_0000);
      wr(`RX_CFG_OFS, 32'h0001_0000);
      host.dword_read();
      repeat (3) @(negedge clock_i);
      check(32'(irq), 32'h0000_0000);
      rd(`INT_STS_OFS, 32'h0010_0000);
      rd(`RX_CFG_OFS, 32'h0000_0000);
   end
   endtask

   task automatic t_offset();
   begin
      wr(`RX_CFG_OFS, 32'h0000_0300);
      @(negedge clock_i);
      check(32'(read_cfg.lead_offset), 32'h0000_0003);
      // Only the DWORD part changes while running
      wr(`RX_CFG_OFS, 32'h0005_1F00);
      @(negedge clock_i);
      check(32'(read_cfg.lead_offset), 32'h0000_0003);
      host.dword_read();
      @(negedge clock_i);
      check(32'(read_cfg.lead_offset), 32'h0000_001F);
   end
   endtask

   // ***************************************************
   // Run control
   // ***************************************************
   task automatic end_of_test();
   begin
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask

   initial
   begin
      #20000;
      fails++;
      end_of_test();
   end

   initial
   begin
      repeat (3) @(negedge clock_i);
      rstn_i = 1'b1;
      t_reset();
      t_align();
      t_reserved();
      t_count();
      t_offset();
      end_of_test();
   end
endmodule
